// file: inc/spisd_pkg.sv
package spisd_pkg;

   // -------------------------------------------------------------------
   // Register field positions
   // -------------------------------------------------------------------
   localparam int unsigned CFG_MASTER_BIT   = 6;
   localparam int unsigned CFG_CLOCK_POLARITY_SEL_BIT    = 5;
   localparam int unsigned CFG_CLOCK_PHASE_SEL_BIT    = 4;
   localparam int unsigned CTL_EN_BIT       = 0;
   localparam int unsigned CTL_FOURWIRE_BIT = 2;
   localparam int unsigned DMA_CFG_IRQ_BIT  = 7;
   localparam int unsigned EXT_INTERRUPT_ENABLE_TWO_DMA_BIT     = 5;

   // -------------------------------------------------------------------
   // Codes and counts
   // -------------------------------------------------------------------
   localparam logic [7:0] DMA_REQ_MASK = 8'h7F;
   localparam logic [7:0] DMA_REQ_TX   = 8'h03;
   localparam logic [7:0] DMA_REQ_RX   = 8'h04;
   localparam logic [7:0] DMA_MODE_NOWRAP = 8'h00;
   localparam int unsigned BYTE_BITS   = 8;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [3:0] EDGE_FIRST   = 4'h1;
   localparam logic [3:0] EDGE_LAST    = 4'hF;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;
   localparam logic [15:0] WORD_ONE    = 16'h0001;

   typedef enum logic [2:0] {
      SPISD_IDLE,
      SPISD_FETCH,
      SPISD_SHIFT,
      SPISD_STORE,
      SPISD_NEXT
   } spisd_mstate_t;

endpackage : spisd_pkg

// file: rtl/spisd_core.sv
`timescale 1ns/1ps
`default_nettype none

module spisd_core
   import spisd_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [7:0]       spiConfigReg,
   input  wire logic [7:0]       spiControlReg,
   input  wire logic [7:0]       spiClockRateReg,
   input  wire logic             dataWrStb,
   input  wire logic [7:0]       dataWrByte,
   output logic      [7:0]       dataRdByte,
   output logic                  transferDoneFlag,
   input  wire logic             doneClr,
   input  wire logic [1:0][7:0]  dmaChannelConfig,
   input  wire logic [1:0][7:0]  dmaChannelMode,
   input  wire logic [1:0][15:0] dmaBaseAddress,
   input  wire logic [1:0][15:0] dmaTransferSize,
   input  wire logic [1:0]       dmaOffsetClr,
   input  wire logic [1:0]       dmaChannelEnables,
   input  wire logic [1:0]       dmaFlagClr,
   input  wire logic [7:0]       extInterruptEnableTwo,
   output logic      [1:0]       dmaInterruptFlags,
   output logic                  dmaIrq,
   output logic                  memReq,
   output logic                  memWe,
   output logic      [15:0]      memAddr,
   output logic      [7:0]       memWdata,
   input  wire logic [7:0]       memRdata,
   input  wire logic             memAck,
   input  wire logic             sckLink,
   input  wire logic             sckIn,
   output logic                  sckOut,
   output logic                  sckOe,
   input  wire logic             mosiIn,
   output logic                  mosiOut,
   output logic                  mosiOe,
   input  wire logic             misoIn,
   output logic                  misoOut,
   output logic                  misoOe,
   input  wire logic             selIn_b,
   output logic                  selOut_b,
   output logic                  selOe
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic chanFor(input logic [1:0][7:0] cfgs, input logic [7:0] code);
      chanFor = ((cfgs[1] & DMA_REQ_MASK) == code);
   endfunction : chanFor

   typedef struct packed {
      spisd_mstate_t   mState;
      logic [7:0]      txBuf;
      logic            txBufFull;
      logic [7:0]      txShift;
      logic            txShiftFull;
      logic            txFirst;
      logic [7:0]      rxBuf;
      logic            done;
      logic [2:0]      rxTogSync;
      logic [2:0]      sckSync;
      logic [1:0]      selSync;
      logic [1:0]      misoSync;
      logic            misoOut;
      logic            misoOe;
      logic            sckOut;
      logic            sckOe;
      logic            mosiOut;
      logic            mosiOe;
      logic            selOut_b;
      logic            selOe;
      logic [7:0]      divCnt;
      logic [3:0]      edgeCnt;
      logic [7:0]      mShift;
      logic [7:0]      mRx;
      logic [1:0][15:0] off;
      logic [1:0]      flags;
      logic            irq;
      logic            memReq;
      logic            memWe;
      logic [15:0]     memAddr;
      logic [7:0]      memWdata;
   } spisd_sys_t;

   spisd_sys_t s_reg;
   spisd_sys_t s_next;

   // -------------------------------------------------------------------
   // Link domain receive shifter
   // -------------------------------------------------------------------
   // The sample edge is the rising edge of the SCK level adjusted for
   // polarity and phase; polarity and phase must be changed only while idle.
   logic       sampClk;
   logic       frameOff;
   logic       slaveMode_reg;
   logic [2:0] lnkCnt_reg;
   logic [7:0] lnkShift_reg;
   logic [7:0] lnkHold_reg;
   logic       lnkTog_reg;

   assign sampClk  = sckLink ^ spiConfigReg[CFG_CLOCK_POLARITY_SEL_BIT] ^ spiConfigReg[CFG_CLOCK_PHASE_SEL_BIT];
   assign frameOff = ~slaveMode_reg | (spiControlReg[CTL_FOURWIRE_BIT] & selIn_b);

   // The link clock stops between frames, so the bit position is cleared
   // by the deselect level itself rather than by a clock edge.
   // bit counter
   always_ff @(posedge sampClk or posedge frameOff)
   begin
      if (frameOff)
      begin
         lnkCnt_reg   <= 3'h0;
         lnkShift_reg <= BYTE_ZERO;
      end
      else
      begin
         lnkCnt_reg   <= lnkCnt_reg + 3'h1;
         lnkShift_reg <= {lnkShift_reg[6:0], mosiIn};
      end
   end

   always_ff @(posedge sampClk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lnkHold_reg <= BYTE_ZERO;
         lnkTog_reg  <= 1'b0;
      end
      else if (!frameOff && lnkCnt_reg == BIT_LAST)
      begin
         lnkHold_reg <= {lnkShift_reg[6:0], mosiIn};
         lnkTog_reg  <= ~lnkTog_reg;
      end
   end

   // -------------------------------------------------------------------
   // System domain
   // -------------------------------------------------------------------
   logic spiEn;
   logic master;
   logic cpha;
   logic fourWire;
   logic txCh;
   logic rxCh;
   logic byteIn;
   logic selOn;
   logic sckLvl;
   logic sckLvlOld;
   logic shiftEdge;
   logic tick;
   logic lastEdge;
   logic sampleNow;
   logic shiftNow;

   assign spiEn    = spiControlReg[CTL_EN_BIT];
   assign master   = spiConfigReg[CFG_MASTER_BIT];
   assign cpha     = spiConfigReg[CFG_CLOCK_PHASE_SEL_BIT];
   assign fourWire = spiControlReg[CTL_FOURWIRE_BIT];
   assign txCh     = chanFor(dmaChannelConfig, DMA_REQ_TX);
   assign rxCh     = chanFor(dmaChannelConfig, DMA_REQ_RX);

   always_comb
   begin
      s_next = s_reg;
      // Synchronisers; the first stage feeds only the second.
      s_next.rxTogSync = {s_reg.rxTogSync[1:0], lnkTog_reg};
      s_next.sckSync   = {s_reg.sckSync[1:0], sckIn};
      s_next.selSync   = {s_reg.selSync[0], selIn_b};
      s_next.misoSync  = {s_reg.misoSync[0], misoIn};

      byteIn    = s_reg.rxTogSync[2] ^ s_reg.rxTogSync[1];
      selOn     = ~fourWire | ~s_reg.selSync[1];
      sckLvl    = s_reg.sckSync[1] ^ spiConfigReg[CFG_CLOCK_POLARITY_SEL_BIT];
      sckLvlOld = s_reg.sckSync[2] ^ spiConfigReg[CFG_CLOCK_POLARITY_SEL_BIT];
      shiftEdge = cpha ? (sckLvl & ~sckLvlOld) : (~sckLvl & sckLvlOld);
      tick      = (s_reg.divCnt == spiClockRateReg);
      lastEdge  = (s_reg.edgeCnt == EDGE_LAST);
      sampleNow = (s_reg.edgeCnt[0] == cpha);
      // Phase 1 shows the first bit before the leading edge, so that edge shifts nothing.
      shiftNow  = ~sampleNow && !(cpha && (s_reg.edgeCnt + 4'h1) == EDGE_FIRST);

      if (byteIn)
         s_next.rxBuf = lnkHold_reg;

      if (dataWrStb)
      begin
         s_next.txBuf     = dataWrByte;
         s_next.txBufFull = 1'b1;
      end

      if (byteIn && !master)
      begin
         s_next.txShiftFull = 1'b0;
         s_next.txFirst     = 1'b1;
         if (s_reg.txBufFull)
         begin
            s_next.txShift     = s_reg.txBuf;
            s_next.txShiftFull = 1'b1;
            s_next.txBufFull   = dataWrStb;
         end
      end
      else if (s_next.txBufFull && !s_reg.txShiftFull)
      begin
         s_next.txShift     = s_next.txBuf;
         s_next.txShiftFull = 1'b1;
         s_next.txBufFull   = 1'b0;
         s_next.txFirst     = cpha;
      end

      s_next.misoOe = 1'b0;
      s_next.sckOe  = 1'b0;
      s_next.mosiOe = 1'b0;
      s_next.selOe  = 1'b0;
      if (spiEn && !master)
      begin
         s_next.misoOe = selOn;
         // shift only on external edges
         // In phase 0 the trailing edge that closes a byte comes after the
         // reload, so it must not shift the byte that was just loaded.
         if (!selOn)
            s_next.txFirst = cpha;
         else if (shiftEdge && !byteIn)
         begin
            s_next.txFirst = 1'b0;
            if (!s_reg.txFirst)
               s_next.txShift = {s_reg.txShift[6:0], 1'b0};
         end
      end
      s_next.misoOut = s_next.txShift[BYTE_BITS-1];

      if (doneClr)
         s_next.done = 1'b0;
      if (byteIn && !master)
         s_next.done = 1'b1;

      for (int c = 0; c < 2; c++)
      begin
         if (dmaOffsetClr[c])
            s_next.off[c] = WORD_ZERO;
         if (dmaFlagClr[c])
            s_next.flags[c] = 1'b0;
      end

      s_next.memReq = 1'b0;
      s_next.memWe  = 1'b0;
      s_next.divCnt = WORD_ZERO[7:0];
      unique case (s_reg.mState)
         SPISD_IDLE:
         begin
            s_next.sckOut   = spiConfigReg[CFG_CLOCK_POLARITY_SEL_BIT];
            s_next.selOut_b = 1'b1;
            if (spiEn && master && (&dmaChannelEnables) && txCh != rxCh &&
                s_reg.off[txCh] != dmaTransferSize[txCh])
            begin
               s_next.memReq  = 1'b1;
               s_next.memAddr = dmaBaseAddress[txCh] + s_reg.off[txCh];
               s_next.mState  = SPISD_FETCH;
            end
         end
         SPISD_FETCH:
         begin
            s_next.memReq = ~memAck;
            if (memAck)
            begin
               s_next.mShift   = memRdata;
               s_next.mosiOut  = memRdata[BYTE_BITS-1];
               s_next.selOut_b = 1'b0;
               s_next.edgeCnt  = 4'h0;
               s_next.mState   = SPISD_SHIFT;
            end
         end
         SPISD_SHIFT:
         begin
            s_next.divCnt = tick ? BYTE_ZERO : s_reg.divCnt + 8'h01;
            if (tick)
            begin
               s_next.sckOut  = ~s_reg.sckOut;
               s_next.edgeCnt = s_reg.edgeCnt + 4'h1;
               if (sampleNow)
                  s_next.mRx = {s_reg.mRx[6:0], s_reg.misoSync[1]};
               else if (shiftNow)
               begin
                  s_next.mShift  = {s_reg.mShift[6:0], 1'b0};
                  s_next.mosiOut = s_reg.mShift[6];
               end
               if (lastEdge)
               begin
                  s_next.memReq   = 1'b1;
                  s_next.memWe    = 1'b1;
                  s_next.memAddr  = dmaBaseAddress[rxCh] + s_reg.off[rxCh];
                  s_next.memWdata = sampleNow ? {s_reg.mRx[6:0], s_reg.misoSync[1]} :
                                    s_reg.mRx;
                  s_next.mState   = SPISD_STORE;
               end
            end
         end
         SPISD_STORE:
         begin
            s_next.memReq = ~memAck;
            s_next.memWe  = ~memAck;
            if (memAck)
               s_next.mState = SPISD_NEXT;
         end
         SPISD_NEXT:
         begin
            s_next.mState = SPISD_IDLE;
            for (int c = 0; c < 2; c++)
            begin
               if (s_reg.off[c] + WORD_ONE == dmaTransferSize[c])
               begin
                  s_next.flags[c] = 1'b1;
                  s_next.off[c] = (dmaChannelMode[c] == DMA_MODE_NOWRAP) ?
                                  dmaTransferSize[c] : WORD_ZERO;
               end
               else
                  s_next.off[c] = s_reg.off[c] + WORD_ONE;
            end
         end
      endcase
      if (spiEn && master)
      begin
         s_next.sckOe  = 1'b1;
         s_next.mosiOe = 1'b1;
         s_next.selOe  = fourWire;
      end

      s_next.irq = extInterruptEnableTwo[EXT_INTERRUPT_ENABLE_TWO_DMA_BIT] &
                   |(s_next.flags & {dmaChannelConfig[1][DMA_CFG_IRQ_BIT],
                                     dmaChannelConfig[0][DMA_CFG_IRQ_BIT]});
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_reg          <= '0;
         s_reg.mState   <= SPISD_IDLE;
         s_reg.selOut_b <= 1'b1;
         s_reg.txFirst  <= 1'b1;
         slaveMode_reg  <= 1'b0;
      end
      else
      begin
         s_reg         <= s_next;
         slaveMode_reg <= spiEn & ~master;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign dataRdByte        = s_reg.rxBuf;
   assign transferDoneFlag  = s_reg.done;
   assign dmaInterruptFlags = s_reg.flags;
   assign dmaIrq            = s_reg.irq;
   assign memReq            = s_reg.memReq;
   assign memWe             = s_reg.memWe;
   assign memAddr           = s_reg.memAddr;
   assign memWdata          = s_reg.memWdata;
   assign sckOut            = s_reg.sckOut;
   assign sckOe             = s_reg.sckOe;
   assign mosiOut           = s_reg.mosiOut;
   assign mosiOe            = s_reg.mosiOe;
   assign misoOut           = s_reg.misoOut;
   assign misoOe            = s_reg.misoOe;
   assign selOut_b          = s_reg.selOut_b;
   assign selOe             = s_reg.selOe;

endmodule : spisd_core

`default_nettype wire

// file: verif/spisd_link_peer.sv
`timescale 1ns/1ps
`default_nettype none

module spisd_link_peer
(
   input  wire logic clk,
   input  wire logic misoW,
   input  wire logic mosiW,
   input  wire logic selW_b,
   output logic      pSck,
   output logic      pMosi,
   output logic      pSel_b,
   output logic      pMiso
);
   // ----------------------------------------------------------------
   // Far side of the serial link
   // ----------------------------------------------------------------
   initial
   begin
      pSck = 1'b0;
      pMosi = 1'b0;
      pSel_b = 1'b1;
      pMiso = 1'b0;
   end

   // Slave echoes inverted.
   // A released line toggles so that no stale level can pass for data.
   always @(posedge clk or mosiW or selW_b)
      pMiso = selW_b ? ~pMiso : ~mosiW;

   // Framed master byte; pol is the idle clock level.
   task automatic xfer(input logic [7:0] tx, input logic pol, output logic [7:0] rx);
      int i;
      pSck = pol;
      #40;
      pSel_b = 1'b0;
      for (i = 7; i >= 0; i--)
      begin
         pMosi = tx[i];
         pSck = 1'b0;
         #80;
         pSck = 1'b1;
         rx[i] = misoW;
         #80;
         pSck = pol;
      end
      #40;
      pSel_b = 1'b1;
      pMosi = ~pMosi;
   endtask : xfer
endmodule : spisd_link_peer

`default_nettype wire

// file: verif/spisd_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module spisd_core_asserts
   import spisd_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  spiConfigReg,
   input wire logic [7:0]  spiControlReg,
   input wire logic [7:0]  dataRdByte,
   input wire logic        transferDoneFlag,
   input wire logic        doneClr,
   input wire logic [7:0]  extInterruptEnableTwo,
   input wire logic [1:0]  dmaInterruptFlags,
   input wire logic [1:0]  dmaFlagClr,
   input wire logic        dmaIrq,
   input wire logic        memReq,
   input wire logic        memWe,
   input wire logic [15:0] memAddr,
   input wire logic        memAck,
   input wire logic        sckOe,
   input wire logic        misoOe,
   input wire logic        selIn_b,
   input wire logic        selOe
);
   // ----------------------------------------------------------------
   // Port checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Three-wire framing has no select, so only four-wire slaves are judged.
   logic slv;
   assign slv = spiControlReg[CTL_EN_BIT] && spiControlReg[CTL_FOURWIRE_BIT]
                && !spiConfigReg[CFG_MASTER_BIT];

   AST_SLAVE_QUIET: assert property (
      !spiConfigReg[CFG_MASTER_BIT] [*3] |-> !sckOe && !selOe && !memReq)
      else $error("slave drove clock, select or memory");
   AST_MASTER_CLK: assert property (
      sckOe |-> spiConfigReg[CFG_MASTER_BIT] && spiControlReg[CTL_EN_BIT])
      else $error("clock driven outside master mode");
   AST_MISO_ON: assert property (
      (slv && !selIn_b) [*5] |-> misoOe)
      else $error("MISO not driven while selected");
   AST_MISO_OFF: assert property (
      $rose(selIn_b) |-> ##[0:4] !misoOe)
      else $error("MISO not released after deselect");
   AST_DONE_HOLD: assert property (
      transferDoneFlag && !doneClr |=> transferDoneFlag)
      else $error("done flag dropped without clear");
   AST_RX_ON_DONE: assert property (
      slv && !$stable(dataRdByte) |-> transferDoneFlag)
      else $error("receive buffer moved without done");
   AST_IRQ_GATE: assert property (
      !extInterruptEnableTwo[EXT_INTERRUPT_ENABLE_TWO_DMA_BIT] [*2] |-> !dmaIrq)
      else $error("interrupt passed a closed gate");
   AST_MEM_HOLD: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
      else $error("memory request changed before answer");
   AST_FLAG_HOLD: assert property (
      dmaInterruptFlags[1] && !dmaFlagClr[1] |=> dmaInterruptFlags[1])
      else $error("channel flag dropped without clear");

   CVR_DONE: cover property ($rose(transferDoneFlag));
   CVR_IRQ: cover property ($rose(dmaIrq));
   CVR_RELEASE: cover property ($fell(misoOe));
endmodule : spisd_core_asserts

bind spisd_core spisd_core_asserts CHK (
   .clk                   (clk),
   .rst_b                 (rst_b),
   .spiConfigReg          (spiConfigReg),
   .spiControlReg         (spiControlReg),
   .dataRdByte            (dataRdByte),
   .transferDoneFlag      (transferDoneFlag),
   .doneClr               (doneClr),
   .extInterruptEnableTwo (extInterruptEnableTwo),
   .dmaInterruptFlags     (dmaInterruptFlags),
   .dmaFlagClr            (dmaFlagClr),
   .dmaIrq                (dmaIrq),
   .memReq                (memReq),
   .memWe                 (memWe),
   .memAddr               (memAddr),
   .memAck                (memAck),
   .sckOe                 (sckOe),
   .misoOe                (misoOe),
   .selIn_b               (selIn_b),
   .selOe                 (selOe)
);

`default_nettype wire

// file: verif/spisd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spisd_core_tb;
   logic             clk, rst_b, dataWrStb, doneClr, transferDoneFlag, dmaIrq;
   logic             memReq, memWe, memAck, sckLink, sckIn, sckOut, sckOe;
   logic             mosiIn, mosiOut, mosiOe, misoIn, misoOut, misoOe;
   logic             selIn_b, selOut_b, selOe, pSck, pMosi, pSel_b, pMiso;
   logic [7:0]       spiConfigReg, spiControlReg, spiClockRateReg, dataWrByte;
   logic [7:0]       dataRdByte, extInterruptEnableTwo, memWdata, memRdata, rxByte;
   logic [1:0][7:0]  dmaChannelConfig, dmaChannelMode;
   logic [1:0][15:0] dmaBaseAddress, dmaTransferSize;
   logic [1:0]       dmaOffsetClr, dmaChannelEnables, dmaFlagClr, dmaInterruptFlags;
   logic [15:0]      memAddr;
   logic [24:0]      memLog [$];
   int               err_count, comparisons, i;

   // ----------------------------------------------------------------
   // Pins, memory and clock
   // ----------------------------------------------------------------
   assign sckIn = sckOe ? sckOut : pSck;
   assign sckLink = sckIn;
   assign mosiIn = mosiOe ? mosiOut : pMosi;
   assign misoIn = misoOe ? misoOut : pMiso;
   assign selIn_b = selOe ? selOut_b : pSel_b;
   assign memRdata = (memAddr[0] === 1'b1) ? 8'h0F : 8'h96;

   spisd_core DUT (.*);

   spisd_link_peer PRT (.clk(clk), .misoW(misoIn), .mosiW(mosiIn), .selW_b(selIn_b),
                        .pSck(pSck), .pMosi(pMosi), .pSel_b(pSel_b), .pMiso(pMiso));

   // Memory answers each request half a cycle late and logs what it saw.
   always @(negedge clk)
   begin
      memAck <= memReq && !memAck;
      if (memReq && !memAck)
         memLog.push_back({memWe, memAddr, memWdata});
   end

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask : chk

   task automatic stop_test;
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic wrByte(input logic [7:0] b);
      @(negedge clk);
      dataWrByte = b;
      dataWrStb = 1'b1;
      @(negedge clk);
      dataWrStb = 1'b0;
   endtask : wrByte

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_b = 1'b0;
      {dataWrStb, doneClr, dataWrByte, dmaOffsetClr, dmaChannelEnables, dmaFlagClr} = 16'h0000;
      spiConfigReg = 8'h00;
      spiControlReg = 8'h05;
      spiClockRateReg = 8'h03;
      extInterruptEnableTwo = 8'h20;
      dmaChannelConfig = 16'h8403;
      dmaChannelMode = 16'h0000;
      dmaBaseAddress = 32'h2000_1000;
      dmaTransferSize = 32'h0002_0002;
      repeat (12) @(negedge clk);
      chk(selOut_b, 1'b1, "select idle level");
      chk({transferDoneFlag, misoOe, sckOe, memReq, dmaIrq}, 5'h00, "idle outputs");
      rst_b = 1'b1;
      wrByte(8'hA5);
      wrByte(8'h3C);
      PRT.xfer(8'h5A, 1'b0, rxByte);
      repeat (10) @(negedge clk);
      chk(rxByte, 8'hA5, "first byte on MISO");
      chk(dataRdByte, 8'h5A, "first received byte");
      chk(transferDoneFlag, 1'b1, "done flag after byte");
      chk(misoOe, 1'b0, "MISO released");
      doneClr = 1'b1;
      @(negedge clk);
      doneClr = 1'b0;
      @(negedge clk);
      chk(transferDoneFlag, 1'b0, "done flag cleared");
      fork
         PRT.xfer(8'hC3, 1'b0, rxByte);
         begin
            #700;
            chk(dataRdByte, 8'h5A, "receive buffer held");
         end
      join
      repeat (10) @(negedge clk);
      chk(rxByte, 8'h3C, "queued byte on MISO");
      chk(dataRdByte, 8'hC3, "second received byte");
      // Idle-high clock with phase 1: shift on leading, sample on trailing edge.
      spiConfigReg = 8'h30;
      wrByte(8'h69);
      PRT.xfer(8'h96, 1'b1, rxByte);
      repeat (10) @(negedge clk);
      chk(rxByte, 8'h69, "byte out with polarity and phase set");
      chk(dataRdByte, 8'h96, "byte in with polarity and phase set");
      chk(misoOe, 1'b0, "MISO released after second mode");
      // Offsets and flags cleared, then both channels enabled.
      spiConfigReg = 8'h40;
      dmaOffsetClr = 2'h3;
      dmaFlagClr = 2'h3;
      @(negedge clk);
      dmaOffsetClr = 2'h0;
      dmaFlagClr = 2'h0;
      dmaChannelEnables = 2'h3;
      for (i = 0; i < 1000 && dmaInterruptFlags !== 2'h3; i++)
         @(negedge clk);
      chk(dmaInterruptFlags, 2'h3, "channel flags after run");
      if (dmaInterruptFlags !== 2'h3)
         stop_test();
      chk(dmaIrq, 1'b1, "interrupt raised");
      repeat (200) @(negedge clk);
      chk(memLog.size(), 4, "memory access count");
      for (i = 0; i < 4; i++)
      begin
         chk(memLog[i][24:8], {i[0], (i[0] ? 16'h2000 : 16'h1000) + 16'(i / 2)}, "access");
         if (i[0])
            chk(memLog[i][7:0], 8'(~(i > 1 ? 8'h0F : 8'h96)), "stored byte");
      end
      extInterruptEnableTwo = 8'h00;
      repeat (3) @(negedge clk);
      chk(dmaIrq, 1'b0, "interrupt gated");
      dmaChannelEnables = 2'h0;
      @(negedge clk);
      dmaFlagClr = 2'h3;
      @(negedge clk);
      dmaFlagClr = 2'h0;
      @(negedge clk);
      chk(dmaInterruptFlags, 2'h0, "channel flags cleared");
      stop_test();
   end
endmodule : spisd_core_tb

`default_nettype wire
